// [bench/sclkc_osc_model.sv]
// Behavioural oscillator bank that feeds the clock controller
`default_nettype none
module sclkc_osc_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Per-source stop control, used to kill the crystal
	input wire logic [3:0] stop_i,
	// Oscillator levels: fast RC, slow RC, crystal, user clock
	output logic [3:0] clk_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt [4];
	// Four sources, each with its own half period of 3, 5, 7, 9 cycles
	// A stopped source finishes its high phase, then sits low until released
	always_ff @(posedge clk_i) begin
		for (int i = 0; i < 4; i++) begin
			if (rst_i) begin
				cnt[i] <= 0;
				clk_o[i] <= 1'b0;
			end else if (!stop_i[i] || clk_o[i]) begin
				cnt[i] <= (cnt[i] >= 2 * i + 2) ? 0 : cnt[i] + 1;
				if (cnt[i] >= 2 * i + 2) clk_o[i] <= ~clk_o[i];
			end
		end
	end
endmodule // sclkc_osc_model
`default_nettype wire

// [bench/tb.sv]
// Self-checking bench for the system clock controller
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst, cyc, stb, we, ack, halt, sys_clk, core_clk;
	logic pin, pin_oe, irq;
	logic [7:0] adr, opt, nopt, pclk;
	logic [9:0] acc;
	logic sys_clk_d;
	logic [3:0] sel, sclk, rdy, stop, trim;
	logic [31:0] wdat, rdat, dat_o;
	logic [31:0] seed = 32'h20;
	int error_cnt = 0;
	int comparisons = 0;
	int run = 0;
	logic [31:0] mdl [logic [7:0]];
	logic [31:0] msk [logic [7:0]];
	sclkc_osc_model osc (.clk_i(clk), .rst_i(rst), .stop_i(stop),
		.clk_o(sclk));
	sclkc_top dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.src_clk_i(sclk), .src_rdy_i(rdy), .halt_i(halt),
		.trim_option_byte_i(opt), .trim_option_byte_inverse_i(nopt),
		.sys_clk_o(sys_clk), .core_clk_o(core_clk), .periph_clk_o(pclk),
		.clock_output_pin_o(pin), .clock_output_pin_oe_o(pin_oe),
		.rc_trim_o(trim), .irq_o(irq));
	// Free-running 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// One classic cycle; the first edge keeps the strobe low a cycle
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		chk("ack", 32'h1, {31'h0, ack});
		rdat = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		if (w && msk.exists(a)) mdl[a] = d & msk[a];
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk($sformatf("reg %h", a), e, rdat);
	endtask
	// Poll status until the masked field matches or the limit runs out
	task automatic wait_st(input logic [31:0] m, input logic [31:0] v,
		input int lim);
		int n;
		n = 0;
		do begin
			wb(1'b0, sclkc_pkg::ADR_STATUS, 32'h0);
			n++;
		end while ((rdat & m) !== v && n < lim);
		chk("status", v, rdat & m);
	endtask
	task automatic watch(input int cyc_n);
		acc = 10'h000;
		repeat (cyc_n) begin
			@(posedge clk);
			// Core and pin kept apart from the peripheral lanes
			acc = acc | {core_clk, pin, pclk};
		end
	endtask
	task automatic print_verdict();
		$display("Checks %0d, errors %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// No source changeover may leave a pulse shorter than 3 cycles
	always @(posedge clk) begin
		if (rst) begin
			run <= 0;
		end else if (sys_clk !== sys_clk_d) begin
			chk("pulse", 32'h1, {31'h0, run >= 2});
			run <= 0;
		end else begin
			run <= run + 1;
		end
	end
	always @(posedge clk) sys_clk_d <= sys_clk;
	// Watchdog, well above the expected run length
	initial begin
		repeat (30000) @(posedge clk);
		error_cnt++;
		print_verdict();
	end
	initial begin
		{cyc, stb, we, halt, adr, wdat} = '0;
		sel = 4'hF;
		rdy = 4'h3;
		stop = 4'h0;
		opt = 8'h00;
		nopt = 8'hFF;
		rst = 1'b1;
		mdl[sclkc_pkg::ADR_CTRL] = 32'h33;
		mdl[sclkc_pkg::ADR_PGATE] = 32'hFF;
		mdl[sclkc_pkg::ADR_PINOUT] = 32'h0;
		mdl[sclkc_pkg::ADR_TRIM] = 32'h0;
		mdl[sclkc_pkg::ADR_IMASK] = 32'h0;
		msk[sclkc_pkg::ADR_CTRL] = 32'h3F;
		msk[sclkc_pkg::ADR_PGATE] = 32'hFF;
		msk[sclkc_pkg::ADR_PINOUT] = 32'h07;
		msk[sclkc_pkg::ADR_TRIM] = 32'h0F;
		msk[sclkc_pkg::ADR_IMASK] = 32'h07;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		// Reset values, status on fast RC divided by eight
		foreach (mdl[a]) rd(a, mdl[a]);
		rd(sclkc_pkg::ADR_STATUS, 32'h0C);
		rd(sclkc_pkg::ADR_ISTAT, 32'h0);
		rd(8'h1C, 32'h0);
		// Trim in full, reduced and inconsistent option formats
		for (int k = 0; k < 6; k++) begin
			opt <= {7'h0, k[1]};
			nopt <= ~{7'h0, k[1]} ^ {7'h0, k[2]};
			seed = lfsr(seed);
			wb(1'b1, sclkc_pkg::ADR_TRIM, seed);
			rd(sclkc_pkg::ADR_TRIM, mdl[sclkc_pkg::ADR_TRIM]);
			chk("trim", mdl[sclkc_pkg::ADR_TRIM] & ((k[1] && !k[2]) ?
				32'hB : 32'hF), {28'h0, trim});
		end
		// Random peripheral gating, core gating and clock output
		seed = lfsr(seed);
		wb(1'b1, sclkc_pkg::ADR_PGATE, seed);
		wb(1'b1, sclkc_pkg::ADR_CTRL, 32'h23);
		wb(1'b1, sclkc_pkg::ADR_PINOUT, 32'h05);
		watch(120);
		chk("pclk", {24'h0, seed[7:0]}, {24'h0, acc[7:0]});
		chk("core", 32'h0, {31'h0, acc[9]});
		chk("pin", 32'h1, {31'h0, acc[8]});
		chk("pin_oe", 32'h1, {31'h0, pin_oe});
		wb(1'b1, sclkc_pkg::ADR_CTRL, 32'h33);
		watch(120);
		chk("core", 32'h1, {31'h0, acc[9]});
		// Switch to the crystal only once it reports ready
		wb(1'b1, sclkc_pkg::ADR_CTRL, 32'h3B);
		repeat (60) @(posedge clk);
		wait_st(32'h13, 32'h10, 1);
		rdy <= 4'h7;
		wait_st(32'h13, 32'h02, 40);
		rd(sclkc_pkg::ADR_CTRL, mdl[sclkc_pkg::ADR_CTRL]);
		// Crystal dies; fallback raises a flag and a masked interrupt
		wb(1'b1, sclkc_pkg::ADR_IMASK, 32'h1);
		stop <= 4'h4;
		wait_st(32'h2F, 32'h2C, 150);
		wb(1'b0, sclkc_pkg::ADR_ISTAT, 32'h0);
		chk("istat", 32'h1, rdat & 32'h1);
		chk("irq", 32'h1, {31'h0, irq});
		wb(1'b1, sclkc_pkg::ADR_IMASK, 32'h0);
		chk("irq", 32'h0, {31'h0, irq});
		wb(1'b1, sclkc_pkg::ADR_ISTAT, 32'h7);
		rd(sclkc_pkg::ADR_ISTAT, 32'h0);
		// Halt on slow RC, wake on fast RC /8, then restore slow RC
		stop <= 4'h0;
		wb(1'b1, sclkc_pkg::ADR_CTRL, 32'h37);
		wait_st(32'h0F, 32'h0D, 40);
		wb(1'b1, sclkc_pkg::ADR_IMASK, 32'h4);
		halt <= 1'b1;
		// Long enough for the changeover to fast RC /8 inside Halt
		repeat (100) @(posedge clk);
		wait_st(32'hC0, 32'h40, 1);
		halt <= 1'b0;
		wait_st(32'h0F, 32'h0C, 1);
		chk("irq", 32'h0, {31'h0, irq});
		wait_st(32'h0F, 32'h0D, 60);
		chk("irq", 32'h1, {31'h0, irq});
		print_verdict();
	end
endmodule // tb
`default_nettype wire

// [hdl/sclkc_monitor.sv]
// Watches an external source for missing edges
`default_nettype none
module sclkc_monitor (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Supervised level, already synchronised
	input wire logic en_i,
	input wire logic lvl_i,
	// One-cycle failure pulse
	output logic fail_o
);
	localparam logic [sclkc_pkg::FAIL_W-1:0] LIMIT =
		sclkc_pkg::FAIL_W'(sclkc_pkg::FAIL_CYC);

	typedef struct packed {
		logic prev;
		logic [sclkc_pkg::FAIL_W-1:0] cnt;
		logic fail;
	} sclkc_mon_type;

	sclkc_mon_type s_r, s_nxt;

	// Any edge restarts the count; the pulse fires once per outage
	always_comb begin
		s_nxt = s_r;
		s_nxt.prev = lvl_i;
		s_nxt.fail = 1'b0;
		if (!en_i || lvl_i != s_r.prev) begin
			s_nxt.cnt = '0;
		end else if (s_r.cnt != LIMIT) begin
			s_nxt.cnt = s_r.cnt + 1'b1;
			s_nxt.fail = (s_nxt.cnt == LIMIT); // [R8]
		end
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign fail_o = s_r.fail;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_fail_quiet;
		s_r.fail |-> (s_r.cnt == LIMIT) && $past(en_i);
	endproperty
	a_fail_quiet: assert property (p_fail_quiet) // [R8]
		else $error("failure reported without a full quiet period");
endmodule // sclkc_monitor
`default_nettype wire

// [hdl/sclkc_pkg.sv]
// Shared constants and types for the system clock controller
`default_nettype none
package sclkc_pkg;
	// Core clock rate
	localparam int CLK_MHZ = 100;
	// Settling time after wakeup before the saved source is restored
	localparam int WAKE_STAB_NS = 1000;
	localparam int WAKE_STAB_CYC = (WAKE_STAB_NS * CLK_MHZ + 999) / 1000;
	localparam int WAKE_W = $clog2(WAKE_STAB_CYC + 1);
	// Quiet time on an external source that counts as a failure
	localparam int FAIL_NS = 2000;
	localparam int FAIL_CYC = (FAIL_NS * CLK_MHZ + 999) / 1000;
	localparam int FAIL_W = $clog2(FAIL_CYC + 1);
	// Register byte offsets
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_STATUS = 8'h04;
	localparam logic [7:0] ADR_PGATE = 8'h08;
	localparam logic [7:0] ADR_PINOUT = 8'h0C;
	localparam logic [7:0] ADR_TRIM = 8'h10;
	localparam logic [7:0] ADR_ISTAT = 8'h14;
	localparam logic [7:0] ADR_IMASK = 8'h18;
	// Interrupt status bit positions
	localparam int IRQ_FAIL = 0;
	localparam int IRQ_SWITCH = 1;
	localparam int IRQ_WAKE = 2;
	// Trim layout: magnitude in the low bits, sign on top
	localparam logic [3:0] TRIM_RESET = 4'h0;
	localparam logic [3:0] TRIM_FULL_MASK = 4'hF;
	localparam logic [3:0] TRIM_REDUCED_MASK = 4'hB;
	localparam int TRIM_WIDTH_SEL_BIT = 0;
	localparam logic [7:0] PGATE_RESET = 8'hFF;
	// Oscillator sources
	typedef enum logic [1:0] {
		SRC_FAST_RC,
		SRC_SLOW_RC,
		SRC_XTAL,
		SRC_USER
	} sclkc_src_type;
	// Source plus fast-RC prescaler code (0:/1 1:/2 2:/4 3:/8)
	typedef struct packed {
		sclkc_src_type sel;
		logic [1:0] div;
	} sclkc_cfg_type;
	localparam logic [1:0] DIV_BY8 = 2'h3;
	localparam sclkc_cfg_type CFG_RESET = '{SRC_FAST_RC, DIV_BY8};
	// Control register layout
	typedef struct packed {
		logic mon_en;
		logic core_en;
		sclkc_cfg_type cfg;
	} sclkc_ctrl_type;
	localparam sclkc_ctrl_type CTRL_RESET = '{1'b1, 1'b1, CFG_RESET};
	// Clock output pin configuration (0:system 1:fast 2:slow 3:crystal)
	typedef struct packed {
		logic en;
		logic [1:0] sel;
	} sclkc_pin_type;
	localparam sclkc_pin_type PIN_RESET = '{1'b0, 2'h0};
	// Power modes
	typedef enum logic [1:0] {
		ST_RUN,
		ST_HALT,
		ST_WAKE
	} sclkc_mode_type;
endpackage
`default_nettype wire

// [hdl/sclkc_switch.sv]
// Glitch-free source selector with fast RC prescaler
`default_nettype none
module sclkc_switch (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Oscillator levels and ready flags
	input wire logic [3:0] src_clk_i,
	input wire logic [3:0] src_rdy_i,
	// Requested configuration
	input wire sclkc_pkg::sclkc_cfg_type req_i,
	// Results
	output sclkc_pkg::sclkc_cfg_type cur_o,
	output logic [3:0] lvl_o,
	output logic sys_clk_o,
	output logic switched_o
);
	typedef struct packed {
		logic [3:0] s1;
		logic [3:0] s2;
		logic [3:0] r1;
		logic [3:0] r2;
		logic prev_fast;
		logic [2:0] cnt;
		sclkc_pkg::sclkc_cfg_type cur;
		logic out;
		logic sw;
	} sclkc_sw_type;

	sclkc_sw_type s_r, s_nxt;
	logic lvl_cur, lvl_req, go;

	// Level of a configuration; only the fast RC goes through the prescaler
	function automatic logic level_of(sclkc_pkg::sclkc_cfg_type c,
		logic [3:0] lv, logic [2:0] cnt);
		logic l;
		l = lv[c.sel]; // [R10]
		if (c.sel == sclkc_pkg::SRC_FAST_RC && c.div != 2'h0) begin
			l = cnt[c.div - 2'h1];
		end
		return l;
	endfunction

	// Hand over only when the target is ready and both clocks sit low
	always_comb begin
		s_nxt = s_r;
		s_nxt.s1 = src_clk_i;
		s_nxt.s2 = s_r.s1;
		s_nxt.r1 = src_rdy_i;
		s_nxt.r2 = s_r.r1;
		s_nxt.prev_fast = s_r.s2[0];
		if (s_r.s2[0] && !s_r.prev_fast) begin
			s_nxt.cnt = s_r.cnt + 3'h1;
		end
		lvl_cur = level_of(s_r.cur, s_r.s2, s_r.cnt);
		lvl_req = level_of(req_i, s_r.s2, s_r.cnt);
		go = (req_i != s_r.cur) && s_r.r2[req_i.sel] // [R3]
			&& !lvl_cur && !lvl_req && !s_r.out; // [R4]
		s_nxt.sw = go;
		if (go) begin
			s_nxt.cur = req_i;
		end
		s_nxt.out = go ? 1'b0 : lvl_cur;
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_r <= '{default: '0, cur: sclkc_pkg::CFG_RESET};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign cur_o = s_r.cur;
	assign lvl_o = s_r.s2;
	assign sys_clk_o = s_r.out;
	assign switched_o = s_r.sw;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_no_runt;
		(s_nxt.cur != s_r.cur) |-> !s_r.out ##1 !s_r.out;
	endproperty
	a_no_runt: assert property (p_no_runt) // [R4]
		else $error("source changed while clock was high");

	property p_ready_first;
		(s_nxt.cur != s_r.cur) |-> s_r.r2[req_i.sel] ##1 s_r.sw;
	endproperty
	a_ready_first: assert property (p_ready_first) // [R3]
		else $error("switched to a source that was not ready");
endmodule // sclkc_switch
`default_nettype wire

// [hdl/sclkc_top.sv]
// System clock controller: source select, gating, wakeup, failure fallback
// What this block does
// R1 - After reset the system runs from fast RC divided by eight.
// R2 - Software may change source and divider any time through a register.
// R3 - A switch keeps the old source until the new one reports ready.
// R4 - Changeovers produce no truncated pulses or glitches.
// R5 - Software can stop the core clock and each peripheral clock.
// R6 - On wakeup the system runs from fast RC divided by eight.
// R7 - After a settling delay it returns to the source chosen before Halt.
// R8 - A failed external source makes the system fall back to fast RC /8.
// R9 - A selectable internal clock can be driven onto an output pin.
// R10 - Four sources: fast RC, slow RC, crystal and external user clock.
// R11 - Trim register holds three magnitude bits and a sign, all writable.
// R12 - Software trim never alters the factory calibration value.
// R13 - Option bit with valid complement selects two magnitude bits plus sign.
// R14 - Failure fallback sets a readable flag that can raise an interrupt.
//
// Implementation choices: the address map and the Wishbone interface to the registers.
`default_nettype none
module sclkc_top (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Oscillators: fast RC, slow RC, crystal, user clock
	input wire logic [3:0] src_clk_i,
	input wire logic [3:0] src_rdy_i,
	// Core power state and trim option bytes
	input wire logic halt_i,
	input wire logic [7:0] trim_option_byte_i,
	input wire logic [7:0] trim_option_byte_inverse_i,
	// Distributed clocks
	output logic sys_clk_o,
	output logic core_clk_o,
	output logic [7:0] periph_clk_o,
	// Clock output pin
	output logic clock_output_pin_o,
	output logic clock_output_pin_oe_o,
	// Oscillator trim and interrupt
	output logic [3:0] rc_trim_o,
	output logic irq_o
);
	localparam int WAKE_D = sclkc_pkg::WAKE_STAB_CYC;
	localparam logic [sclkc_pkg::WAKE_W-1:0] WAKE_LAST =
		sclkc_pkg::WAKE_W'(sclkc_pkg::WAKE_STAB_CYC - 1);

	typedef struct packed {
		sclkc_pkg::sclkc_mode_type mode;
		logic [sclkc_pkg::WAKE_W-1:0] wcnt;
		sclkc_pkg::sclkc_ctrl_type ctrl;
		logic [7:0] pgate;
		sclkc_pkg::sclkc_pin_type pin;
		sclkc_pkg::sclkc_pin_type pin_l;
		logic [3:0] trim;
		logic [2:0] istat;
		logic [2:0] imask;
		logic fallback;
		logic core_en_l;
		logic [7:0] pg_l;
		logic core_clk;
		logic [7:0] pclk;
		logic pin_out;
		logic ack;
		logic [31:0] rdat;
	} sclkc_state_type;

	sclkc_state_type s_r, s_nxt;
	sclkc_pkg::sclkc_cfg_type req_cfg, cur_cfg;
	logic [3:0] lvl;
	logic sys_lvl, switched, mon_fail, mon_en, ext_sel;
	logic bus_req, wr, fail_ev, wake_done, opt_ok, reduced;
	logic [2:0] ev;
	logic [7:0] status;

	// Level that the clock output pin would carry for a configuration
	function automatic logic pin_src(sclkc_pkg::sclkc_pin_type p,
		logic sys, logic [3:0] lv);
		logic l;
		unique case (p.sel)
			2'h0: l = sys;
			2'h1: l = lv[0];
			2'h2: l = lv[1];
			2'h3: l = lv[2];
		endcase
		return l;
	endfunction

	// Configuration steered into the selector
	always_comb begin
		if (s_r.mode != sclkc_pkg::ST_RUN || s_r.fallback) begin
			req_cfg = sclkc_pkg::CFG_RESET; // [R6] [R8]
		end else begin
			req_cfg = s_r.ctrl.cfg; // [R7]
		end
	end

	sclkc_switch u_switch (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.src_clk_i(src_clk_i),
		.src_rdy_i(src_rdy_i),
		.req_i(req_cfg),
		.cur_o(cur_cfg),
		.lvl_o(lvl),
		.sys_clk_o(sys_lvl),
		.switched_o(switched)
	);

	// Only the external sources are supervised
	assign ext_sel = (s_r.ctrl.cfg.sel == sclkc_pkg::SRC_XTAL)
		|| (s_r.ctrl.cfg.sel == sclkc_pkg::SRC_USER);
	assign mon_en = s_r.ctrl.mon_en && ext_sel && !s_r.fallback;

	sclkc_monitor u_monitor (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.en_i(mon_en),
		.lvl_i(lvl[s_r.ctrl.cfg.sel]),
		.fail_o(mon_fail)
	);

	// Reduced trim format only when the option byte pair is consistent
	assign opt_ok = (trim_option_byte_i == ~trim_option_byte_inverse_i);
	assign reduced = opt_ok
		&& trim_option_byte_i[sclkc_pkg::TRIM_WIDTH_SEL_BIT]; // [R13]

	// Bus decode: one wait state, ack dropped the cycle after it was given
	assign bus_req = wb_cyc_i && wb_stb_i && !s_r.ack;
	assign wr = bus_req && wb_we_i && wb_sel_i[0];

	assign fail_ev = mon_fail && mon_en;
	assign wake_done = (s_r.mode == sclkc_pkg::ST_WAKE)
		&& (s_r.wcnt == WAKE_LAST);
	assign ev = {wake_done, switched, fail_ev}; // [R14]

	// Status view of the live selection
	assign status = {s_r.mode, s_r.fallback, cur_cfg != req_cfg,
		cur_cfg.div, cur_cfg.sel};

	// Next-state logic for registers, power mode and clock gates
	always_comb begin
		s_nxt = s_r;
		s_nxt.ack = bus_req;
		s_nxt.rdat = 32'h0;
		// Sticky events: a new event beats a clear in the same cycle
		s_nxt.istat = s_r.istat | ev; // [R14]
		if (bus_req && !wb_we_i) begin
			unique case (wb_adr_i)
				sclkc_pkg::ADR_CTRL: s_nxt.rdat[5:0] = s_r.ctrl;
				sclkc_pkg::ADR_STATUS: s_nxt.rdat[7:0] = status;
				sclkc_pkg::ADR_PGATE: s_nxt.rdat[7:0] = s_r.pgate;
				sclkc_pkg::ADR_PINOUT: s_nxt.rdat[2:0] = s_r.pin;
				sclkc_pkg::ADR_TRIM: s_nxt.rdat[3:0] = s_r.trim;
				sclkc_pkg::ADR_ISTAT: s_nxt.rdat[2:0] = s_r.istat;
				sclkc_pkg::ADR_IMASK: s_nxt.rdat[2:0] = s_r.imask;
				default: s_nxt.rdat = 32'h0;
			endcase
		end
		if (wr) begin
			unique case (wb_adr_i)
				sclkc_pkg::ADR_CTRL: begin
					// A fresh selection also releases a failure fallback
					s_nxt.ctrl = sclkc_pkg::sclkc_ctrl_type'(wb_dat_i[5:0]); // [R2]
					s_nxt.fallback = 1'b0;
				end
				sclkc_pkg::ADR_PGATE: s_nxt.pgate = wb_dat_i[7:0]; // [R5]
				sclkc_pkg::ADR_PINOUT:
					s_nxt.pin = sclkc_pkg::sclkc_pin_type'(wb_dat_i[2:0]); // [R9]
				sclkc_pkg::ADR_TRIM: s_nxt.trim = wb_dat_i[3:0]; // [R11]
				sclkc_pkg::ADR_ISTAT:
					s_nxt.istat = (s_r.istat & ~wb_dat_i[2:0]) | ev;
				sclkc_pkg::ADR_IMASK: s_nxt.imask = wb_dat_i[2:0];
				default: s_nxt.imask = s_r.imask;
			endcase
		end
		// Failure forces the divided fast RC until software reselects
		if (fail_ev) begin
			s_nxt.fallback = 1'b1; // [R8]
		end
		// Power mode sequencing
		unique case (s_r.mode)
			sclkc_pkg::ST_RUN: begin
				if (halt_i) begin
					s_nxt.mode = sclkc_pkg::ST_HALT;
				end
			end
			sclkc_pkg::ST_HALT: begin
				if (!halt_i) begin
					s_nxt.mode = sclkc_pkg::ST_WAKE; // [R6]
					s_nxt.wcnt = '0;
				end
			end
			sclkc_pkg::ST_WAKE: begin
				s_nxt.wcnt = s_r.wcnt + 1'b1;
				if (wake_done) begin
					s_nxt.mode = sclkc_pkg::ST_RUN; // [R7]
				end
			end
			default: s_nxt.mode = sclkc_pkg::ST_RUN;
		endcase
		// Gate enables move only while the clock is low, so no runt edges
		if (!sys_lvl) begin
			s_nxt.core_en_l = s_r.ctrl.core_en
				&& (s_r.mode != sclkc_pkg::ST_HALT); // [R5]
			s_nxt.pg_l = s_r.pgate;
		end
		s_nxt.core_clk = sys_lvl && s_r.core_en_l; // [R5]
		s_nxt.pclk = {8{sys_lvl}} & s_r.pg_l;
		// Pin configuration swaps only while old and new levels are low
		if (!s_r.pin_out && !pin_src(s_r.pin, sys_lvl, lvl)) begin
			s_nxt.pin_l = s_r.pin;
		end
		s_nxt.pin_out = s_r.pin_l.en && pin_src(s_r.pin_l, sys_lvl, lvl); // [R9]
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_r <= '{
				mode: sclkc_pkg::ST_RUN,
				ctrl: sclkc_pkg::CTRL_RESET, // [R1]
				pgate: sclkc_pkg::PGATE_RESET,
				pin: sclkc_pkg::PIN_RESET,
				pin_l: sclkc_pkg::PIN_RESET,
				trim: sclkc_pkg::TRIM_RESET,
				pg_l: sclkc_pkg::PGATE_RESET,
				core_en_l: 1'b1,
				default: '0
			};
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs; the factory calibration lives elsewhere and is only offset
	assign wb_ack_o = s_r.ack;
	assign wb_dat_o = s_r.rdat;
	assign sys_clk_o = sys_lvl;
	assign core_clk_o = s_r.core_clk;
	assign periph_clk_o = s_r.pclk;
	assign clock_output_pin_o = s_r.pin_out;
	assign clock_output_pin_oe_o = s_r.pin_l.en;
	assign rc_trim_o = s_r.trim & (reduced ? sclkc_pkg::TRIM_REDUCED_MASK
		: sclkc_pkg::TRIM_FULL_MASK); // [R12] [R13]
	assign irq_o = |(s_r.istat & s_r.imask);

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_wake_entry;
		$rose(s_r.mode == sclkc_pkg::ST_WAKE);
	endsequence

	sequence s_back_in_run;
		(s_r.mode == sclkc_pkg::ST_RUN) && !$past(s_r.mode == sclkc_pkg::ST_RUN);
	endsequence

	property p_reset_cfg;
		$past(rst_i) |-> (req_cfg == sclkc_pkg::CFG_RESET)
			&& (cur_cfg == sclkc_pkg::CFG_RESET);
	endproperty
	a_reset_cfg: assert property (p_reset_cfg) // [R1]
		else $error("not on fast RC divided by eight after reset");

	property p_ctrl_write;
		(wr && wb_adr_i == sclkc_pkg::ADR_CTRL) |=>
			(s_r.ctrl == $past(wb_dat_i[5:0])) && !s_r.fallback;
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) // [R2]
		else $error("control write did not take");

	property p_gate_core;
		!s_r.core_en_l |=> !core_clk_o;
	endproperty
	a_gate_core: assert property (p_gate_core) // [R5]
		else $error("core clock ran while gated");

	property p_wake_fast;
		s_wake_entry |-> (req_cfg == sclkc_pkg::CFG_RESET) [*2];
	endproperty
	a_wake_fast: assert property (p_wake_fast) // [R6]
		else $error("wakeup did not request divided fast RC");

	property p_wake_return;
		s_wake_entry |-> ##WAKE_D s_back_in_run
			##0 (s_r.fallback || req_cfg == s_r.ctrl.cfg);
	endproperty
	a_wake_return: assert property (p_wake_return) // [R7]
		else $error("saved source not restored after settling time");

	property p_fail_fallback;
		fail_ev |=> s_r.fallback && (req_cfg == sclkc_pkg::CFG_RESET);
	endproperty
	a_fail_fallback: assert property (p_fail_fallback) // [R8]
		else $error("clock failure did not force fallback");

	property p_pin_off;
		!s_r.pin_l.en |=> !clock_output_pin_o;
	endproperty
	a_pin_off: assert property (p_pin_off) // [R9]
		else $error("clock output pin toggled while disabled");

	property p_trim_reduced;
		reduced |-> (rc_trim_o[2] == 1'b0)
			&& (rc_trim_o[3] == s_r.trim[3]);
	endproperty
	a_trim_reduced: assert property (p_trim_reduced) // [R13]
		else $error("reduced trim format not applied");

	property p_fail_flag;
		fail_ev |=> s_r.istat[sclkc_pkg::IRQ_FAIL]
			##0 (irq_o == s_r.imask[sclkc_pkg::IRQ_FAIL] || irq_o);
	endproperty
	a_fail_flag: assert property (p_fail_flag) // [R14]
		else $error("failure flag not set");
endmodule // sclkc_top
`default_nettype wire
